// File: logic/sde_map.svh
/*
 * Register indices, field positions, reset values and video timing counts
 * for the SD mode/timing register bank.
 * Assumes byte address = 4 * index on a 32-bit AXI4-Lite bus.
 */
`ifndef SDE_MAP_SVH
`define SDE_MAP_SVH

// ==========================================================================
// register indices (byte address is index * 4)
`define SDE_IDX_FMT 8'h88
`define SDE_IDX_LIM 8'h89
`define SDE_IDX_SYNC 8'h8a
`define SDE_IDX_CNT 8'hf0
`define SDE_IDX_STAT 8'hf1

// ==========================================================================
// reset values
`define SDE_RST_FMT 8'h00
`define SDE_RST_LIM 8'h00
`define SDE_RST_SYNC 8'h08
`define SDE_RST_CNT 8'h00

// ==========================================================================
// writable bit masks; reserved bits read as shown
`define SDE_MASK_FMT 8'hfe
`define SDE_MASK_LIM 8'h3b
`define SDE_FIX_SYNC 8'h08

// ==========================================================================
// field positions
`define SDE_FMT_NONINT 1
`define SDE_FMT_DBUF 2
`define SDE_FMT_IN_LO 3
`define SDE_FMT_IN_HI 4
`define SDE_FMT_DNR 5
`define SDE_FMT_GAMMA 6
`define SDE_FMT_CURVE 7
`define SDE_LIM_US_LO 0
`define SDE_LIM_US_HI 1
`define SDE_LIM_BB 3
`define SDE_LIM_CD_LO 4
`define SDE_LIM_CD_HI 5
`define SDE_SYNC_MASTER 0
`define SDE_SYNC_TM_LO 1
`define SDE_SYNC_TM_HI 2
`define SDE_SYNC_LD_LO 4
`define SDE_SYNC_LD_HI 5
`define SDE_CNT_PAL 0
`define SDE_CNT_FREE 6

// ==========================================================================
// bus answers
`define SDE_RESP_OKAY 2'h0
`define SDE_RESP_SLVERR 2'h2

// ==========================================================================
// last sample of a line, last line of a frame, last line of field 1
`define SDE_NTSC_HLAST 10'h359
`define SDE_PAL_HLAST 10'h35f
`define SDE_NTSC_VLAST 10'h20c
`define SDE_PAL_VLAST 10'h270
`define SDE_NTSC_F1LAST 10'h106
`define SDE_PAL_F1LAST 10'h138

`endif

// File: logic/sde_pkg.sv
/*
 * Types shared by the SD mode/timing register bank.
 * Assumes sde_map.svh for all numeric constants.
 */
package sde_pkg;
   typedef enum logic [1:0] {
      SDE_IN_8BIT = 2'b00,
      SDE_IN_16BIT = 2'b01,
      SDE_IN_10BIT = 2'b10,
      SDE_IN_RSVD = 2'b11
   } sde_in_fmt_t;

   typedef enum logic [2:0] {
      SDE_REG_NONE = 3'b000,
      SDE_REG_FMT = 3'b001,
      SDE_REG_LIM = 3'b010,
      SDE_REG_SYNC = 3'b011,
      SDE_REG_CNT = 3'b100,
      SDE_REG_STAT = 3'b101
   } sde_reg_t;
endpackage : sde_pkg

// File: logic/sde_cnt_if.sv
/*
 * Carrier between the register bank and its line/field counter.
 * Assumes both ends on the same clock.
 */
`timescale 1ns/1ps
interface sde_cnt_if;
   logic free_run;
   logic pal;
   logic hsync_n;
   logic vsync_n;
   logic [9:0] h_count;
   logic [9:0] v_count;
   logic field;
   logic frame_start;

   modport regs (output free_run, pal, hsync_n, vsync_n,
                 input h_count, v_count, field, frame_start);
   modport cnt (input free_run, pal, hsync_n, vsync_n,
                output h_count, v_count, field, frame_start);
endinterface : sde_cnt_if

// File: logic/sde_timing_cnt.sv
/*
 * Horizontal/vertical/field counter for the SD timing path.
 * Assumes sync inputs on the interface are already synchronised, active low.
 */
`timescale 1ns/1ps
`include "sde_map.svh"
module sde_timing_cnt (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control and counts
   sde_cnt_if.cnt cif
);
   logic hs_d;
   logic vs_d;
   logic hs_fall;
   logic vs_fall;
   logic [9:0] hlast;
   logic [9:0] vlast;
   logic [9:0] f1last;
   logic line_end;

   assign hlast = cif.pal ? `SDE_PAL_HLAST : `SDE_NTSC_HLAST;
   assign vlast = cif.pal ? `SDE_PAL_VLAST : `SDE_NTSC_VLAST;
   assign f1last = cif.pal ? `SDE_PAL_F1LAST : `SDE_NTSC_F1LAST;
   assign hs_fall = hs_d & ~cif.hsync_n;
   assign vs_fall = vs_d & ~cif.vsync_n;
   assign line_end = cif.h_count == hlast;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hs_d <= 1'b1;
         vs_d <= 1'b1;
      end else begin
         hs_d <= cif.hsync_n;
         vs_d <= cif.vsync_n;
      end
   end

   // ==========================================================================
   // horizontal count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cif.h_count <= 10'h000;
      end else if (cif.free_run) begin
         cif.h_count <= hs_fall ? 10'h000 : 10'(cif.h_count + 10'h001);
      end else begin
         cif.h_count <= line_end ? 10'h000 : 10'(cif.h_count + 10'h001);
      end
   end

   // ==========================================================================
   // vertical count, field and frame marker
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cif.v_count <= 10'h000;
         cif.field <= 1'b0;
         cif.frame_start <= 1'b0;
      end else if (cif.free_run) begin
         cif.frame_start <= vs_fall & cif.field;
         if (vs_fall) begin
            cif.v_count <= 10'h000;
            cif.field <= ~cif.field;
         end else if (hs_fall) begin
            cif.v_count <= 10'(cif.v_count + 10'h001);
         end
      // wrap at frame end, field set after the last line of field 1
      end else begin
         cif.frame_start <= line_end && cif.v_count == vlast;
         if (line_end) begin
            if (cif.v_count == vlast) begin
               cif.v_count <= 10'h000;
               cif.field <= 1'b0;
            end else begin
               cif.v_count <= 10'(cif.v_count + 10'h001);
               if (cif.v_count == f1last) begin
                  cif.field <= 1'b1;
               end
            end
         end
      end
   end

   // ==========================================================================
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_auto_line_wrap: assert property (!cif.free_run && line_end |=> cif.h_count == 10'h000)
      else $error("line did not wrap in auto mode");
   a_auto_frame_wrap: assert property (
      !cif.free_run && line_end && cif.v_count == vlast
      |=> cif.v_count == 10'h000 && cif.frame_start && !cif.field)
      else $error("frame did not wrap in auto mode");
   a_free_run_count: assert property (
      cif.free_run && !hs_fall |=> cif.h_count == 10'($past(cif.h_count) + 10'h001))
      else $error("free running count did not advance");
   a_free_ext_wrap: assert property (cif.free_run && hs_fall |=> cif.h_count == 10'h000)
      else $error("external sync did not wrap line");
   c_free_vsync: cover property (cif.free_run && vs_fall);
endmodule : sde_timing_cnt

// File: logic/sde_mode_regs.sv
/*
 * SD mode and timing register bank on an AXI4-Lite slave, with the
 * line/field counter it steers.
 * Assumes aclk is the pixel-path clock; sync pins are asynchronous.
 */
// Summary of operation
// - With counter mode cleared the counters wrap at each line and frame end; the field bit sets at the end of field 1 and clears at frame end.
// - With counter mode set the counters run freely and wrap on external sync.
// - Format/gamma bit 6 switches SD gamma correction off (0) or on (1).
// - Format/gamma bit 7 selects gamma curve A (0) or curve B (1).
// - Format/gamma bit 5 disables (0) or enables (1) digital noise reduction.
// - Limiter/delay bit 3 puts black burst on the luma converter when set.
`timescale 1ns/1ps
`include "sde_map.svh"
module sde_mode_regs (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // external sync pins, active low
   input wire logic ext_hsync_n,
   input wire logic ext_vsync_n,
   // sd processing controls
   output logic noninterlaced,
   output logic double_buf,
   output sde_pkg::sde_in_fmt_t in_fmt,
   output logic dnr_en,
   output logic gamma_en,
   output logic gamma_curve_b,
   output logic [1:0] undershoot_sel,
   output logic black_burst_luma,
   output logic [1:0] chroma_delay_sel,
   // sd timing controls
   output logic master_mode,
   output logic [1:0] timing_mode,
   output logic [1:0] luma_delay_sel,
   // counter state
   output logic [9:0] h_count,
   output logic [9:0] v_count,
   output logic field
);
   sde_cnt_if cif ();

   logic [7:0] fmt_reg;
   logic [7:0] lim_reg;
   logic [7:0] sync_reg;
   logic [7:0] cnt_reg;
   logic aw_held;
   logic w_held;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   logic apply_now;
   sde_pkg::sde_reg_t wr_sel;
   sde_pkg::sde_reg_t rd_sel;
   logic hs_meta;
   logic vs_meta;

   // ==========================================================================
   // address decode, shared by write and read paths
   function automatic sde_pkg::sde_reg_t reg_decode(input logic [11:0] addr);
      if (addr == {2'b00, `SDE_IDX_FMT, 2'b00}) begin
         return sde_pkg::SDE_REG_FMT;
      end else if (addr == {2'b00, `SDE_IDX_LIM, 2'b00}) begin
         return sde_pkg::SDE_REG_LIM;
      end else if (addr == {2'b00, `SDE_IDX_SYNC, 2'b00}) begin
         return sde_pkg::SDE_REG_SYNC;
      end else if (addr == {2'b00, `SDE_IDX_CNT, 2'b00}) begin
         return sde_pkg::SDE_REG_CNT;
      end else if (addr == {2'b00, `SDE_IDX_STAT, 2'b00}) begin
         return sde_pkg::SDE_REG_STAT;
      end
      return sde_pkg::SDE_REG_NONE;
   endfunction : reg_decode

   assign wr_sel = reg_decode(aw_addr);
   assign rd_sel = reg_decode(s_axi_araddr);
   assign wr_fire = aw_held & w_held & ~s_axi_bvalid;

   // ==========================================================================
   // write channel: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         aw_held <= 1'b0;
         aw_addr <= 12'h000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end else if (!aw_held && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b0;
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end else if (!w_held && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SDE_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wr_sel == sde_pkg::SDE_REG_NONE) ? `SDE_RESP_SLVERR : `SDE_RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================================
   // register storage; only byte lane 0 carries data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fmt_reg <= `SDE_RST_FMT;
         lim_reg <= `SDE_RST_LIM;
         sync_reg <= `SDE_RST_SYNC;
         cnt_reg <= `SDE_RST_CNT;
      end else if (wr_fire && w_strb[0]) begin
         unique case (wr_sel)
            sde_pkg::SDE_REG_FMT: fmt_reg <= w_data[7:0] & `SDE_MASK_FMT;
            sde_pkg::SDE_REG_LIM: lim_reg <= w_data[7:0] & `SDE_MASK_LIM;
            sde_pkg::SDE_REG_SYNC: sync_reg <= w_data[7:0] | `SDE_FIX_SYNC;
            sde_pkg::SDE_REG_CNT: cnt_reg <= w_data[7:0];
            sde_pkg::SDE_REG_STAT: ;
            sde_pkg::SDE_REG_NONE: ;
         endcase
      end
   end

   // ==========================================================================
   // read channel: answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `SDE_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `SDE_RESP_OKAY;
         unique case (rd_sel)
            sde_pkg::SDE_REG_FMT: s_axi_rdata <= {24'h00_0000, fmt_reg};
            sde_pkg::SDE_REG_LIM: s_axi_rdata <= {24'h00_0000, lim_reg};
            sde_pkg::SDE_REG_SYNC: s_axi_rdata <= {24'h00_0000, sync_reg};
            sde_pkg::SDE_REG_CNT: s_axi_rdata <= {24'h00_0000, cnt_reg};
            sde_pkg::SDE_REG_STAT: s_axi_rdata <= {11'h000, field, v_count, h_count};
            sde_pkg::SDE_REG_NONE: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `SDE_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid) begin
         s_axi_rvalid <= ~s_axi_rready;
         s_axi_arready <= s_axi_rready;
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // ==========================================================================
   // active processing controls; with double buffering all but double_buf change only at
   // frame start so a picture never mixes two settings
   assign apply_now = ~fmt_reg[`SDE_FMT_DBUF] | cif.frame_start;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         noninterlaced <= 1'b0;
         double_buf <= 1'b0;
         dnr_en <= 1'b0;
         gamma_en <= 1'b0;
         gamma_curve_b <= 1'b0;
         undershoot_sel <= 2'b00;
         black_burst_luma <= 1'b0;
         chroma_delay_sel <= 2'b00;
      end else begin
         double_buf <= fmt_reg[`SDE_FMT_DBUF];
         if (apply_now) begin
            noninterlaced <= fmt_reg[`SDE_FMT_NONINT];
            dnr_en <= fmt_reg[`SDE_FMT_DNR];
            gamma_en <= fmt_reg[`SDE_FMT_GAMMA];
            gamma_curve_b <= fmt_reg[`SDE_FMT_CURVE];
            undershoot_sel <= lim_reg[`SDE_LIM_US_HI:`SDE_LIM_US_LO];
            black_burst_luma <= lim_reg[`SDE_LIM_BB];
            chroma_delay_sel <= lim_reg[`SDE_LIM_CD_HI:`SDE_LIM_CD_LO];
         end
      end
   end

   // reserved input code keeps the previous width rather than guessing one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_fmt <= sde_pkg::SDE_IN_8BIT;
      end else if (apply_now &&
                   fmt_reg[`SDE_FMT_IN_HI:`SDE_FMT_IN_LO] != sde_pkg::SDE_IN_RSVD) begin
         in_fmt <= sde_pkg::sde_in_fmt_t'(fmt_reg[`SDE_FMT_IN_HI:`SDE_FMT_IN_LO]);
      end
   end

   // timing controls are not double buffered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         master_mode <= 1'b0;
         timing_mode <= 2'b00;
         luma_delay_sel <= 2'b00;
      end else begin
         master_mode <= sync_reg[`SDE_SYNC_MASTER];
         timing_mode <= sync_reg[`SDE_SYNC_TM_HI:`SDE_SYNC_TM_LO];
         luma_delay_sel <= sync_reg[`SDE_SYNC_LD_HI:`SDE_SYNC_LD_LO];
      end
   end

   // ==========================================================================
   // sync pin synchronisers and counter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hs_meta <= 1'b1;
         vs_meta <= 1'b1;
         cif.hsync_n <= 1'b1;
         cif.vsync_n <= 1'b1;
      end else begin
         hs_meta <= ext_hsync_n;
         vs_meta <= ext_vsync_n;
         cif.hsync_n <= hs_meta;
         cif.vsync_n <= vs_meta;
      end
   end

   assign cif.free_run = cnt_reg[`SDE_CNT_FREE];
   assign cif.pal = cnt_reg[`SDE_CNT_PAL];
   assign h_count = cif.h_count;
   assign v_count = cif.v_count;
   assign field = cif.field;

   sde_timing_cnt u_cnt (
      .aclk(aclk),
      .aresetn(aresetn),
      .cif(cif)
   );

   // ==========================================================================
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_gamma_enable_out: assert property (
      !fmt_reg[`SDE_FMT_DBUF] |=> gamma_en == $past(fmt_reg[`SDE_FMT_GAMMA]))
      else $error("gamma enable does not follow register");
   a_curve_at_frame: assert property (
      cif.frame_start |=> gamma_curve_b == $past(fmt_reg[`SDE_FMT_CURVE]))
      else $error("gamma curve not applied at frame start");
   a_dnr_after_write: assert property (
      wr_fire && w_strb[0] && wr_sel == sde_pkg::SDE_REG_FMT &&
      !fmt_reg[`SDE_FMT_DBUF] && !w_data[`SDE_FMT_DBUF]
      |=> ##1 dnr_en == $past(w_data[`SDE_FMT_DNR], 2))
      else $error("noise reduction enable lost after write");
   a_black_burst_on: assert property (
      !fmt_reg[`SDE_FMT_DBUF] && lim_reg[`SDE_LIM_BB] |=> black_burst_luma)
      else $error("black burst not enabled");
   a_fmt_reserved_hold: assert property (
      fmt_reg[`SDE_FMT_IN_HI:`SDE_FMT_IN_LO] == 2'b11 |=> $stable(in_fmt))
      else $error("reserved input format changed width");
   a_role_and_mode: assert property (
      1'b1 |=> master_mode == $past(sync_reg[`SDE_SYNC_MASTER]) &&
      timing_mode == $past(sync_reg[`SDE_SYNC_TM_HI:`SDE_SYNC_TM_LO]))
      else $error("role or timing mode does not follow register");
   a_write_answer: assert property (wr_fire |=> s_axi_bvalid)
      else $error("write not answered next cycle");

   c_fmt_write: cover property (wr_fire && wr_sel == sde_pkg::SDE_REG_FMT);
   c_status_read: cover property (s_axi_arvalid && s_axi_arready && rd_sel == sde_pkg::SDE_REG_STAT);
   c_dbuf_apply: cover property (fmt_reg[`SDE_FMT_DBUF] && cif.frame_start);
   c_free_mode: cover property (cif.free_run);
endmodule : sde_mode_regs

// File: tb/sde_mode_regs_bench.sv
/*
 * Self-checking bench for the SD mode/timing register bank.
 * Assumes the bank answers on AXI4-Lite at byte address 4 * index.
 */
`timescale 1ns/1ps
`include "sde_map.svh"
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
   $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module sde_mode_regs_bench;
   // ===================================================================
   // signals
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, v;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, undershoot_sel, chroma_delay_sel, timing_mode;
   logic [1:0] luma_delay_sel, r;
   logic ext_hsync_n, ext_vsync_n, noninterlaced, double_buf, dnr_en, gamma_en;
   logic gamma_curve_b, black_burst_luma, master_mode, field, fp;
   logic [9:0] h_count, v_count, vp;
   sde_pkg::sde_in_fmt_t in_fmt;
   int err_total, checks_done;
   localparam logic [11:0] A_FMT = {2'b00, `SDE_IDX_FMT, 2'b00};
   localparam logic [11:0] A_LIM = {2'b00, `SDE_IDX_LIM, 2'b00};
   localparam logic [11:0] A_SYNC = {2'b00, `SDE_IDX_SYNC, 2'b00};
   localparam logic [11:0] A_CNT = {2'b00, `SDE_IDX_CNT, 2'b00};
   localparam logic [11:0] A_STAT = {2'b00, `SDE_IDX_STAT, 2'b00};
   typedef struct {logic [11:0] a; logic [7:0] d; logic [7:0] rb;} sde_row_t;
   // written value beside the value read back; bit 2 of fmt stays 0 so outputs follow at once
   sde_row_t rows [8] = '{'{A_FMT, 8'he2, 8'he2}, '{A_FMT, 8'h09, 8'h08},
      '{A_FMT, 8'h10, 8'h10}, '{A_LIM, 8'h3b, 8'h3b}, '{A_LIM, 8'h21, 8'h21},
      '{A_SYNC, 8'h07, 8'h0f}, '{A_SYNC, 8'h12, 8'h1a}, '{A_SYNC, 8'h24, 8'h2c}};

   sde_mode_regs DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_hsync_n, .ext_vsync_n, .noninterlaced,
      .double_buf, .in_fmt, .dnr_en, .gamma_en, .gamma_curve_b, .undershoot_sel,
      .black_burst_luma, .chroma_delay_sel, .master_mode, .timing_mode, .luma_delay_sel,
      .h_count, .v_count, .field);

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   // ===================================================================
   // bus tasks
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // no cycle limit here: only the watchdog ends a wait
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      r = s_axi_rresp;
      v = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask : rd

   task automatic rst_chk;
      logic [11:0] ad [4] = '{A_FMT, A_LIM, A_SYNC, A_CNT};
      logic [7:0] ex [4] = '{`SDE_RST_FMT, `SDE_RST_LIM, `SDE_RST_SYNC, `SDE_RST_CNT};
      for (int i = 0; i < 4; i++) begin
         rd(ad[i]);
         `CHK("reset_value", {24'h0, ex[i]}, v)
      end
      rd(A_STAT);
      `CHK("status_field_line", 11'h000, v[20:10])
      `CHK("master_mode", 1'b0, master_mode)
      `CHK("double_buf", 1'b0, double_buf)
      `CHK("in_fmt", 2'b00, in_fmt)
      `CHK("gamma_en", 1'b0, gamma_en)
      `CHK("black_burst", 1'b0, black_burst_luma)
      $display("test reset done");
   endtask : rst_chk

   task automatic wait_hlast(input logic [9:0] last);
      while (h_count !== last) @(negedge aclk);
   endtask : wait_hlast

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test

   // hang guard, far beyond the few thousand cycles the tests need
   initial begin
      #100000;
      err_total++;
      finish_test();
   end

   // ===================================================================
   // main sequence
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {ext_hsync_n, ext_vsync_n} = 2'b11;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rst_chk();
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d, 4'h1);
         `CHK("bresp", 2'h0, r)
         rd(rows[i].a);
         `CHK("rdata", {24'h0, rows[i].rb}, v)
         if (rows[i].a == A_FMT) begin
            `CHK("noninterlaced", rows[i].rb[1], noninterlaced)
            `CHK("double_buf", rows[i].rb[2], double_buf)
            `CHK("in_fmt", rows[i].rb[4:3], in_fmt)
            `CHK("dnr_en", rows[i].rb[5], dnr_en)
            `CHK("gamma_en", rows[i].rb[6], gamma_en)
            `CHK("gamma_curve_b", rows[i].rb[7], gamma_curve_b)
         end else if (rows[i].a == A_LIM) begin
            `CHK("undershoot", rows[i].rb[1:0], undershoot_sel)
            `CHK("black_burst", rows[i].rb[3], black_burst_luma)
            `CHK("chroma_delay", rows[i].rb[5:4], chroma_delay_sel)
         end else begin
            `CHK("master_mode", rows[i].rb[0], master_mode)
            `CHK("timing_mode", rows[i].rb[2:1], timing_mode)
            `CHK("luma_delay", rows[i].rb[5:4], luma_delay_sel)
         end
      end
      $display("test rows done");
      // reserved input code must leave the previous width in force
      wr(A_FMT, 8'h18, 4'h1);
      rd(A_FMT);
      `CHK("in_fmt_hold", 2'b10, in_fmt)
      // disabled byte lane and unmapped place change nothing
      wr(A_LIM, 8'h08, 4'h0);
      rd(A_LIM);
      `CHK("lim_strb", 32'h0000_0021, v)
      wr(12'h100, 8'hff, 4'h1);
      `CHK("bresp_unmapped", `SDE_RESP_SLVERR, r)
      rd(12'h100);
      `CHK("rresp_unmapped", `SDE_RESP_SLVERR, r)
      `CHK("rdata_unmapped", 32'h0000_0000, v)
      $display("test refusals done");
      // auto mode wraps at the line end of the chosen standard
      wait_hlast(`SDE_NTSC_HLAST);
      vp = v_count;
      @(negedge aclk);
      `CHK("h_wrap_auto", 10'h0, h_count)
      `CHK("v_step_auto", vp + 10'h1, v_count)
      // the longer line passes the short line end without wrapping
      wr(A_CNT, 8'h01, 4'h1);
      wait_hlast(`SDE_PAL_HLAST);
      @(negedge aclk);
      `CHK("h_wrap_pal", 10'h0, h_count)
      // free running, wrap only on external sync
      wr(A_CNT, 8'h40, 4'h1);
      wait_hlast(`SDE_NTSC_HLAST);
      @(negedge aclk);
      `CHK("h_free", `SDE_NTSC_HLAST + 10'h1, h_count)
      vp = v_count;
      @(posedge aclk);
      ext_hsync_n <= 1'b0;
      repeat (5) @(negedge aclk);
      `CHK("h_wrap_ext", 10'h001, h_count)
      `CHK("v_step_ext", vp + 10'h1, v_count)
      fp = field;
      @(posedge aclk);
      ext_hsync_n <= 1'b1;
      ext_vsync_n <= 1'b0;
      repeat (5) @(negedge aclk);
      `CHK("v_clear_ext", 10'h0, v_count)
      `CHK("field_ext", ~fp, field)
      @(posedge aclk);
      ext_vsync_n <= 1'b1;
      $display("test counters done");
      // double buffered settings wait for the frame start that the next vsync makes
      wr(A_FMT, 8'hc4, 4'h1);
      rd(A_FMT);
      `CHK("double_buf_on", 1'b1, double_buf)
      `CHK("gamma_en_held", 1'b0, gamma_en)
      `CHK("curve_held", 1'b0, gamma_curve_b)
      @(posedge aclk);
      ext_vsync_n <= 1'b0;
      repeat (5) @(negedge aclk);
      `CHK("gamma_en_frame", 1'b1, gamma_en)
      `CHK("curve_frame", 1'b1, gamma_curve_b)
      `CHK("in_fmt_frame", 2'b00, in_fmt)
      `CHK("field_back", fp, field)
      @(posedge aclk);
      ext_vsync_n <= 1'b1;
      $display("test buffering done");
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rst_chk();
      finish_test();
   end
endmodule : sde_mode_regs_bench
